/* logic/ptc_pkg.sv */
// Package of constants and carrier types for the probe trigger comparator
package ptc_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_PROBES = 4;
    localparam int PROBE_W = 16;

    // ==========================================================
    // Encodings
    typedef enum logic [2:0] {
        PTC_OP_EQ,
        PTC_OP_NE,
        PTC_OP_LT,
        PTC_OP_LE,
        PTC_OP_GT,
        PTC_OP_GE
    } ptc_op_t;

    typedef enum logic [2:0] {
        PTC_RADIX_BIN,
        PTC_RADIX_HEX,
        PTC_RADIX_OCT,
        PTC_RADIX_UDEC,
        PTC_RADIX_SDEC
    } ptc_radix_t;

    // Per-bit binary codes
    typedef enum logic [2:0] {
        PTC_BIT_ZERO,
        PTC_BIT_ONE,
        PTC_BIT_DC,
        PTC_BIT_RISE,
        PTC_BIT_FALL,
        PTC_BIT_BOTH,
        PTC_BIT_NOCHG
    } ptc_bit_code_t;

    typedef enum logic [1:0] {
        PTC_COMB_AND,
        PTC_COMB_OR,
        PTC_COMB_NAND,
        PTC_COMB_NOR
    } ptc_comb_t;

    typedef enum logic [1:0] {
        PTC_SRC_COMPARATOR_ONLY,
        PTC_SRC_COMPARATOR_OR_EXTERNAL,
        PTC_SRC_OTHER
    } ptc_src_t;

    // ==========================================================
    // Per-probe configuration; value holds the digit values, dc_mask the masked bits
    typedef struct packed {
        logic participate;
        ptc_op_t op;
        ptc_radix_t radix;
        logic [PROBE_W-1:0] value;
        logic [PROBE_W-1:0] dc_mask;
        logic [3*PROBE_W-1:0] bit_codes;
    } ptc_probe_cfg_t;

    // Reset values
    localparam logic [PROBE_W-1:0] PROBE_RST = 16'h0000;

endpackage

/* logic/ptc_probe_cmp.sv */
// One probe comparator with sample history
`timescale 1ns/1ps

module ptc_probe_cmp (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sampled probe and configuration
    input wire logic [ptc_pkg::PROBE_W-1:0] sample,
    input wire ptc_pkg::ptc_probe_cfg_t cfg,
    // Result
    output logic match
);

    // ==========================================================
    // Previous sample
    logic [ptc_pkg::PROBE_W-1:0] prev_r;
    logic [ptc_pkg::PROBE_W-1:0] prev_nxt;
    logic match_r;
    logic match_nxt;
    logic [ptc_pkg::PROBE_W-1:0] bit_ok;
    logic [ptc_pkg::PROBE_W-1:0] eff_mask;
    logic [ptc_pkg::PROBE_W-1:0] cur_m;
    logic [ptc_pkg::PROBE_W-1:0] val_m;
    logic rel_ok;
    logic is_bin;

    assign is_bin = (cfg.radix == ptc_pkg::PTC_RADIX_BIN);

    // Per-bit code evaluation
    genvar g;
    generate
        for (g = 0; g < ptc_pkg::PROBE_W; g++) begin : g_bit
            always_comb begin
                unique case (ptc_pkg::ptc_bit_code_t'(cfg.bit_codes[3*g +: 3]))
                    ptc_pkg::PTC_BIT_ZERO: bit_ok[g] = !sample[g];
                    ptc_pkg::PTC_BIT_ONE: bit_ok[g] = sample[g];
                    ptc_pkg::PTC_BIT_DC: bit_ok[g] = 1'b1;
                    ptc_pkg::PTC_BIT_RISE: bit_ok[g] = sample[g] && !prev_r[g];
                    ptc_pkg::PTC_BIT_FALL: bit_ok[g] = !sample[g] && prev_r[g];
                    ptc_pkg::PTC_BIT_BOTH: bit_ok[g] = sample[g] ^ prev_r[g];
                    ptc_pkg::PTC_BIT_NOCHG: bit_ok[g] = sample[g] == prev_r[g];
                    default: bit_ok[g] = 1'b1;
                endcase
            end
        end
    endgenerate

    // Masked bits drop out of both sides of the relation
    always_comb begin
        eff_mask = cfg.dc_mask;
        cur_m = sample & ~eff_mask;
        val_m = cfg.value & ~eff_mask;
        unique case (cfg.op)
            ptc_pkg::PTC_OP_EQ: rel_ok = (cur_m == val_m);
            ptc_pkg::PTC_OP_NE: rel_ok = (cur_m != val_m);
            ptc_pkg::PTC_OP_LT: rel_ok = (cfg.radix == ptc_pkg::PTC_RADIX_SDEC) ?
                ($signed(cur_m) < $signed(val_m)) : (cur_m < val_m);
            ptc_pkg::PTC_OP_LE: rel_ok = (cfg.radix == ptc_pkg::PTC_RADIX_SDEC) ?
                ($signed(cur_m) <= $signed(val_m)) : (cur_m <= val_m);
            ptc_pkg::PTC_OP_GT: rel_ok = (cfg.radix == ptc_pkg::PTC_RADIX_SDEC) ?
                ($signed(cur_m) > $signed(val_m)) : (cur_m > val_m);
            ptc_pkg::PTC_OP_GE: rel_ok = (cfg.radix == ptc_pkg::PTC_RADIX_SDEC) ?
                ($signed(cur_m) >= $signed(val_m)) : (cur_m >= val_m);
            default: rel_ok = 1'b0;
        endcase
    end

    always_comb begin
        prev_nxt = sample;
        if (!cfg.participate) begin
            match_nxt = 1'b1;
        end else if (is_bin) begin
            // Binary: EQ means all bit codes hold, NE its inverse
            match_nxt = (cfg.op == ptc_pkg::PTC_OP_NE) ? !(&bit_ok) : (&bit_ok);
        end else begin
            match_nxt = rel_ok;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_r <= ptc_pkg::PROBE_RST;
            match_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            match_r <= match_nxt;
        end
    end

    assign match = match_r;

endmodule // ptc_probe_cmp

/* logic/ptc_top.sv */
// Basic trigger unit: probe comparators and global combine function
// ==========================================================
// Overview of operation
// - Each comparator offers equal, not equal, less, less-or-equal, greater and greater-or-equal; in binary radix only equal and not equal.
// - Each comparator compares its programmed value with the live probe sample.
// - Binary bit codes are zero, one and don't care, a don't-care bit never blocks a match.
// - Bit codes rise, fall and either-edge match transitions between successive samples.
// - The no-transition bit code matches when the bit equals its previous sample.
// - Hex digits set four compare bits and a don't-care digit masks all four.
// - Octal digits set three compare bits and a don't-care digit masks all three.
// - Unsigned decimal compares unsigned and signed decimal compares in two's complement.
// - The combine function is AND, OR, NAND or NOR over the results of the participating comparators.
// - When probes share one physical port only AND and NAND are supported.
// - Non-participating probes are forced to don't care and do not affect the result.
// - The comparator path acts only in comparator-only or comparator-or-external source mode.
// - In comparator-or-external mode the trigger is the comparator result OR the external input.
`timescale 1ns/1ps

module ptc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Observed design nets, asynchronous to clk
    input wire logic [ptc_pkg::NUM_PROBES*ptc_pkg::PROBE_W-1:0] probe_in,
    input wire logic external_trigger_input,
    // Configuration
    input wire ptc_pkg::ptc_probe_cfg_t [ptc_pkg::NUM_PROBES-1:0] probe_cfg,
    input wire ptc_pkg::ptc_comb_t comb_sel,
    input wire ptc_pkg::ptc_src_t src_sel,
    input wire logic shared_port,
    // Results
    output logic trigger,
    output logic comb_result,
    output logic comb_unsupported
);

    // ==========================================================
    // Input synchronisers
    logic [ptc_pkg::NUM_PROBES*ptc_pkg::PROBE_W-1:0] probe_s1_r;
    logic [ptc_pkg::NUM_PROBES*ptc_pkg::PROBE_W-1:0] probe_s2_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_d_r;
    logic [ptc_pkg::NUM_PROBES-1:0] match;
    logic [ptc_pkg::NUM_PROBES-1:0] part;

    always_ff @(posedge clk) begin
        if (rst) begin
            probe_s1_r <= '0;
            probe_s2_r <= '0;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_d_r <= 1'b0;
        end else begin
            probe_s1_r <= probe_in;
            probe_s2_r <= probe_s1_r;
            ext_s1_r <= external_trigger_input;
            ext_s2_r <= ext_s1_r;
            ext_d_r <= ext_s2_r; // Aligns with comparator latency
        end
    end

    // ==========================================================
    // Comparators
    genvar p;
    generate
        for (p = 0; p < ptc_pkg::NUM_PROBES; p++) begin : g_probe
            ptc_probe_cmp u_cmp (
                .clk(clk),
                .rst(rst),
                .sample(probe_s2_r[p*ptc_pkg::PROBE_W +: ptc_pkg::PROBE_W]),
                .cfg(probe_cfg[p]),
                .match(match[p])
            );
            assign part[p] = probe_cfg[p].participate;

            // A probe left out must never block the combine
            AST_NONPART_MATCH: assert property (@(posedge clk) disable iff (rst)
                (!probe_cfg[p].participate) |=> match[p])
                else $error("non-participating comparator not forced true");
        end
    endgenerate

    // ==========================================================
    // Combine
    function automatic logic comb_f(input ptc_pkg::ptc_comb_t sel,
                                    input logic [ptc_pkg::NUM_PROBES-1:0] m,
                                    input logic [ptc_pkg::NUM_PROBES-1:0] pt);
        logic [ptc_pkg::NUM_PROBES-1:0] any_true;
        logic [ptc_pkg::NUM_PROBES-1:0] any_false;
        any_true = m & pt;
        any_false = ~m & pt;
        unique case (sel)
            ptc_pkg::PTC_COMB_AND: comb_f = ~|any_false;
            ptc_pkg::PTC_COMB_OR: comb_f = |any_true;
            ptc_pkg::PTC_COMB_NAND: comb_f = |any_false;
            ptc_pkg::PTC_COMB_NOR: comb_f = ~|any_true;
        endcase
    endfunction

    logic comb_r;
    logic comb_nxt;
    logic trig_r;
    logic trig_nxt;
    logic unsup_r;
    logic unsup_nxt;
    logic comb_ok;

    always_comb begin
        // OR and NOR refused on a shared port; result held low
        unsup_nxt = shared_port &&
            (comb_sel == ptc_pkg::PTC_COMB_OR || comb_sel == ptc_pkg::PTC_COMB_NOR);
        comb_ok = unsup_nxt ? 1'b0 : comb_f(comb_sel, match, part);
        comb_nxt = comb_ok;
        unique case (src_sel)
            ptc_pkg::PTC_SRC_COMPARATOR_ONLY: trig_nxt = comb_ok;
            ptc_pkg::PTC_SRC_COMPARATOR_OR_EXTERNAL: trig_nxt = comb_ok | ext_d_r;
            default: trig_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            comb_r <= 1'b0;
            trig_r <= 1'b0;
            unsup_r <= 1'b0;
        end else begin
            comb_r <= comb_nxt;
            trig_r <= trig_nxt;
            unsup_r <= unsup_nxt;
        end
    end

    assign trigger = trig_r;
    assign comb_result = comb_r;
    assign comb_unsupported = unsup_r;

    // ==========================================================
    // Checks
    AST_SRC_GATE: assert property (@(posedge clk) disable iff (rst)
        (src_sel == ptc_pkg::PTC_SRC_OTHER) |=> !trigger)
        else $error("trigger outside comparator source modes");
    AST_EXT_OR: assert property (@(posedge clk) disable iff (rst)
        (src_sel == ptc_pkg::PTC_SRC_COMPARATOR_OR_EXTERNAL && ext_d_r) |=> trigger)
        else $error("external trigger not passed");
    AST_CMP_ONLY: assert property (@(posedge clk) disable iff (rst)
        (src_sel == ptc_pkg::PTC_SRC_COMPARATOR_ONLY) |=> (trigger == comb_result))
        else $error("comparator-only trigger mismatch");
    AST_SHARED: assert property (@(posedge clk) disable iff (rst)
        (shared_port && comb_sel == ptc_pkg::PTC_COMB_NOR) |=> (comb_unsupported && !comb_result))
        else $error("NOR accepted on shared port");
    AST_NONPART: assert property (@(posedge clk) disable iff (rst)
        (part == '0 && comb_sel == ptc_pkg::PTC_COMB_AND && !shared_port) |=> comb_result)
        else $error("non-participants affected AND");
    AST_AND: assert property (@(posedge clk) disable iff (rst)
        (comb_sel == ptc_pkg::PTC_COMB_AND && !shared_port) |=> (comb_result == $past(&(match | ~part))))
        else $error("AND combine wrong");
    AST_OR: assert property (@(posedge clk) disable iff (rst)
        (comb_sel == ptc_pkg::PTC_COMB_OR && !shared_port) |=> (comb_result == $past(|(match & part))))
        else $error("OR combine wrong");
    AST_NAND: assert property (@(posedge clk) disable iff (rst)
        (comb_sel == ptc_pkg::PTC_COMB_NAND) |=> (comb_result == $past(|(~match & part))))
        else $error("NAND combine wrong");

    // ==========================================================
    // Sequences for multi-step behaviour
    sequence s_shared_or_nor;
        shared_port &&
            (comb_sel == ptc_pkg::PTC_COMB_OR || comb_sel == ptc_pkg::PTC_COMB_NOR);
    endsequence

    sequence s_shared_nand;
        shared_port && (comb_sel == ptc_pkg::PTC_COMB_NAND);
    endsequence

    sequence s_or_ext_mode;
        src_sel == ptc_pkg::PTC_SRC_COMPARATOR_OR_EXTERNAL;
    endsequence

    sequence s_ext_rise;
        $rose(ext_s2_r);
    endsequence

    // ==========================================================
    // Further checks, four of them built on the sequences
    AST_NOR: assert property (@(posedge clk) disable iff (rst)
        (comb_sel == ptc_pkg::PTC_COMB_NOR && !shared_port) |=> (comb_result == $past(~|(match & part))))
        else $error("NOR combine wrong");

    AST_SHARED_OR_NOR: assert property (@(posedge clk) disable iff (rst)
        s_shared_or_nor |=> (comb_unsupported && !comb_result))
        else $error("OR or NOR accepted on shared port");

    AST_SHARED_NAND: assert property (@(posedge clk) disable iff (rst)
        s_shared_nand |=> (!comb_unsupported && comb_result == $past(|(~match & part))))
        else $error("NAND refused on shared port");

    AST_UNSUP_LOW: assert property (@(posedge clk) disable iff (rst)
        (!shared_port) |=> !comb_unsupported)
        else $error("unsupported flag without shared port");

    AST_NONPART_OR: assert property (@(posedge clk) disable iff (rst)
        (part == '0 && comb_sel == ptc_pkg::PTC_COMB_OR && !shared_port) |=> !comb_result)
        else $error("non-participants affected OR");

    AST_OR_EXT_EQ: assert property (@(posedge clk) disable iff (rst)
        s_or_ext_mode |=> (trigger == (comb_result | $past(ext_d_r))))
        else $error("comparator-or-external trigger wrong");

    // External edge reaches the trigger two edges after the second sync stage
    AST_EXT_PIPE: assert property (@(posedge clk) disable iff (rst)
        (s_ext_rise ##0 s_or_ext_mode ##1 s_or_ext_mode) |=> trigger)
        else $error("external trigger lost in pipeline");

endmodule // ptc_top

/* verification/ptc_net_model.sv */
// Model of the user design nets that feed the probe ports
`timescale 1ns/1ps

module ptc_net_model (
    // Clock
    input wire logic clk,
    // Commanded net values
    input wire logic [63:0] net_val,
    input wire logic net_ext,
    // Nets seen by the trigger unit
    output logic [63:0] probe_in,
    output logic external_trigger_input
);
    // ==========================================================
    // Nets change just after the edge, like registered user logic
    always_ff @(posedge clk) begin
        probe_in <= net_val;
        external_trigger_input <= net_ext;
    end
endmodule // ptc_net_model

/* verification/test_ptc_top.sv */
// Self-checking bench of the probe trigger comparator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

module test_ptc_top;
    logic clk = 0;
    logic rst = 1;
    logic [63:0] nv = '0;
    logic ne = 0;
    logic [63:0] probe_in;
    logic ext_in;
    ptc_pkg::ptc_probe_cfg_t [ptc_pkg::NUM_PROBES-1:0] cfg = '0;
    ptc_pkg::ptc_comb_t comb_sel = ptc_pkg::PTC_COMB_AND;
    ptc_pkg::ptc_src_t src_sel = ptc_pkg::PTC_SRC_COMPARATOR_ONLY;
    logic shared_port = 0;
    logic trigger, comb_result, comb_unsupported;
    int error_cnt = 0;
    int n_checks = 0;
    logic [2:0] dc = ptc_pkg::PTC_BIT_DC;

    ptc_net_model u_ptc_net_model (.clk(clk), .net_val(nv), .net_ext(ne), .probe_in(probe_in),
        .external_trigger_input(ext_in));
    ptc_top u_ptc_top (.clk(clk), .rst(rst), .probe_in(probe_in), .external_trigger_input(ext_in),
        .probe_cfg(cfg), .comb_sel(comb_sel), .src_sel(src_sel), .shared_port(shared_port),
        .trigger(trigger), .comb_result(comb_result), .comb_unsupported(comb_unsupported));

    initial begin
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Helpers; called right after a rising edge
    task automatic prog(int p, logic part, int op, int rdx, logic [15:0] val, logic [15:0] msk);
        cfg[p].participate <= part;
        cfg[p].op <= ptc_pkg::ptc_op_t'(op);
        cfg[p].radix <= ptc_pkg::ptc_radix_t'(rdx);
        cfg[p].value <= val;
        cfg[p].dc_mask <= msk;
    endtask
    // Wait well past the four-edge latency so outputs are steady
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic probe0(logic [15:0] s, logic exp, string nm);
        @(posedge clk);
        nv[15:0] <= s;
        settle();
        `CHK(nm, exp, trigger)
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_ops();
        int s;
        logic e;
        for (int op = 0; op < 6; op++) begin
            for (s = 99; s <= 101; s++) begin
                @(posedge clk);
                prog(0, 1, op, ptc_pkg::PTC_RADIX_UDEC, 16'h0064, 16'h0000);
                case (op)
                    0: e = (s == 100);
                    1: e = (s != 100);
                    2: e = (s < 100);
                    3: e = (s <= 100);
                    4: e = (s > 100);
                    default: e = (s >= 100);
                endcase
                probe0(16'(s), e, "op");
            end
        end
    endtask
    task automatic t_radix();
        @(posedge clk);
        prog(0, 1, ptc_pkg::PTC_OP_LT, ptc_pkg::PTC_RADIX_SDEC, 16'hfffe, 16'h0000);
        probe0(16'hfffd, 1, "sdec neg");
        probe0(16'h0001, 0, "sdec pos");
        @(posedge clk);
        prog(0, 1, ptc_pkg::PTC_OP_EQ, ptc_pkg::PTC_RADIX_HEX, 16'h1200, 16'h00ff);
        probe0(16'h12ab, 1, "hex dc");
        probe0(16'h13ab, 0, "hex digit");
        @(posedge clk);
        prog(0, 1, ptc_pkg::PTC_OP_EQ, ptc_pkg::PTC_RADIX_OCT, 16'h0008, 16'h0007);
        probe0(16'h000f, 1, "oct dc");
        probe0(16'h0017, 0, "oct digit");
    endtask
    task automatic t_bits();
        int hi;
        logic [2:0] cd [5] = '{3'h3, 3'h3, 3'h4, 3'h5, 3'h6};
        logic [15:0] v0 [5] = '{16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0000};
        int exp_hi [5] = '{1, 0, 1, 1, 7};
        @(posedge clk);
        prog(0, 1, ptc_pkg::PTC_OP_EQ, ptc_pkg::PTC_RADIX_BIN, 16'h0000, 16'h0000);
        cfg[0].bit_codes <= {{14{dc}}, 3'(ptc_pkg::PTC_BIT_ZERO), 3'(ptc_pkg::PTC_BIT_ONE)};
        probe0(16'hfff1, 1, "bin one");
        probe0(16'h0003, 0, "bin zero");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            cfg[0].bit_codes <= {{15{dc}}, cd[i]};
            nv[15:0] <= v0[i];
            settle();
            @(posedge clk);
            nv[15:0] <= ~v0[i];
            hi = 0;
            repeat (8) begin
                @(posedge clk);
                #1;
                hi += (trigger === 1'b1);
            end
            `CHK("edge", exp_hi[i], hi)
        end
    endtask
    task automatic t_comb();
        logic [3:0] ex = 4'b0110;
        // Probe 0 matches, probe 1 does not; constant-only probes never take part
        @(posedge clk);
        prog(0, 1, ptc_pkg::PTC_OP_EQ, ptc_pkg::PTC_RADIX_UDEC, 16'h0005, 16'h0000);
        prog(1, 1, ptc_pkg::PTC_OP_EQ, ptc_pkg::PTC_RADIX_UDEC, 16'h0007, 16'h0000);
        nv <= 64'h0000_0000_0000_0005;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            comb_sel <= ptc_pkg::ptc_comb_t'(c);
            settle();
            `CHK("comb", ex[c], comb_result)
        end
        @(posedge clk);
        cfg[1].participate <= 0;
        comb_sel <= ptc_pkg::PTC_COMB_AND;
        settle();
        `CHK("excluded", 1'b1, comb_result)
        @(posedge clk);
        shared_port <= 1;
        comb_sel <= ptc_pkg::PTC_COMB_OR;
        settle();
        `CHK("shared or", 1'b1, comb_unsupported)
        `CHK("shared res", 1'b0, comb_result)
        @(posedge clk);
        comb_sel <= ptc_pkg::PTC_COMB_NOR;
        settle();
        `CHK("shared nor", 1'b1, comb_unsupported)
        `CHK("shared nor res", 1'b0, comb_result)
        @(posedge clk);
        comb_sel <= ptc_pkg::PTC_COMB_NAND;
        settle();
        `CHK("shared nand", 1'b0, comb_unsupported)
        @(posedge clk);
        shared_port <= 0;
    endtask
    task automatic t_src();
        @(posedge clk);
        src_sel <= ptc_pkg::PTC_SRC_OTHER;
        comb_sel <= ptc_pkg::PTC_COMB_AND;
        settle();
        `CHK("src other", 1'b0, trigger)
        @(posedge clk);
        src_sel <= ptc_pkg::PTC_SRC_COMPARATOR_OR_EXTERNAL;
        comb_sel <= ptc_pkg::PTC_COMB_NAND;
        ne <= 1;
        settle();
        `CHK("ext or", 1'b1, trigger)
        @(posedge clk);
        ne <= 0;
        settle();
        `CHK("ext low", 1'b0, trigger)
        @(posedge clk);
        src_sel <= ptc_pkg::PTC_SRC_COMPARATOR_ONLY;
        ne <= 1;
        settle();
        `CHK("ext ignored", 1'b0, trigger)
    endtask

    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        for (int p = 0; p < 4; p++) begin
            cfg[p].bit_codes = {16{dc}};
        end
        repeat (5) @(posedge clk);
        rst <= 0;
        t_ops();
        t_radix();
        t_bits();
        t_comb();
        t_src();
        final_report();
    end

    // Test sequence takes well under 2000 cycles
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
endmodule // test_ptc_top
